// *** pbr_exec.sv ***
// Purpose: Executes page jump, call, returns and rotate left
// Assumes: Fetch unit presents whole instruction; memory answers with mem_ack
// Notes:   Results are valid in the cycle done_ff is high
`timescale 1ns/1ps
module pbr_exec (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              instr_valid,
    input  wire pbr_pkg::pbr_instr_s instr,
    input  wire logic [15:0]       instr_pc,
    input  wire logic [7:0]        cp_in,
    input  wire logic [15:0]       sp_in,
    input  wire logic [3:0]        ccr_in,
    input  wire logic              min_mode,
    input  wire logic [7:0][15:0]  gpr,
    input  wire logic [15:0]       rot_operand,
    input  wire logic              rot_word,
    input  wire logic [15:0]       mem_rdata,
    input  wire logic              mem_ack,
    output logic                   done_ff,
    output logic                   inval_ff,
    output logic                   aerr_ff,
    output logic                   busy_ff,
    output logic [7:0]             cp_ff,
    output logic [15:0]            pc_ff,
    output logic [15:0]            sp_ff,
    output logic [3:0]             ccr_ff,
    output logic [15:0]            result_ff,
    output logic                   mem_req_ff,
    output logic                   mem_we_ff,
    output logic [15:0]            mem_addr_ff,
    output logic [15:0]            mem_wdata_ff
);
    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    function automatic logic [16:0] rot_left(input logic [15:0] op, input logic word);
        rot_left = word ? {op[15], op[14:0], op[15]}
                        : {op[7], 8'h00, op[6:0], op[7]};
    endfunction : rot_left

    pbr_pkg::pbr_state_e state_ff;
    pbr_pkg::pbr_state_e nxt_state;
    logic [7:0]  tgt_cp_ff;
    logic [7:0]  nxt_tgt_cp;
    logic [15:0] tgt_pc_ff;
    logic [15:0] nxt_tgt_pc;
    logic [15:0] imm_ff;
    logic [15:0] nxt_imm;
    logic        nxt_done;
    logic        nxt_inval;
    logic        nxt_aerr;
    logic        nxt_busy;
    logic [7:0]  nxt_cp;
    logic [15:0] nxt_pc;
    logic [15:0] nxt_sp;
    logic [3:0]  nxt_ccr;
    logic [15:0] nxt_result;
    logic        nxt_mem_req;
    logic        nxt_mem_we;
    logic [15:0] nxt_mem_addr;
    logic [15:0] nxt_mem_wdata;

    logic        accept;
    logic        is_abs;
    logic        is_jump;
    logic        is_call;
    logic        is_rtd8;
    logic        is_rtd16;
    logic        is_ret;
    logic        is_rot_left;
    logic        page_op;
    logic [2:0]  rsel;
    logic [2:0]  rsel_pair;
    logic [7:0]  dec_cp;
    logic [15:0] dec_pc;
    logic [15:0] ret_pc;
    logic [15:0] dec_imm;
    logic [16:0] rot_val;

    assign accept    = (state_ff == pbr_pkg::ST_IDLE) && instr_valid;
    assign is_abs    = (instr.b0 == pbr_pkg::OP_JUMP_ABS) || (instr.b0 == pbr_pkg::OP_CALL_ABS);
    // Indirect pair uses n and n+1; n of 7 just wraps to 0, no guard
    assign rsel      = instr.b1[2:0];
    assign rsel_pair = rsel + 3'h1;
    assign is_jump   = (instr.b0 == pbr_pkg::OP_JUMP_ABS) ||
                       ((instr.b0 == pbr_pkg::OP_PAGE_GRP) &&
                        ((instr.b1 & pbr_pkg::SUB_IND_MASK) == pbr_pkg::SUB_JUMP_IND));
    assign is_call   = (instr.b0 == pbr_pkg::OP_CALL_ABS) ||
                       ((instr.b0 == pbr_pkg::OP_PAGE_GRP) &&
                        ((instr.b1 & pbr_pkg::SUB_IND_MASK) == pbr_pkg::SUB_CALL_IND));
    assign is_rtd8   = (instr.b0 == pbr_pkg::OP_PAGE_GRP) && (instr.b1 == pbr_pkg::SUB_RTD8);
    assign is_rtd16  = (instr.b0 == pbr_pkg::OP_PAGE_GRP) && (instr.b1 == pbr_pkg::SUB_RTD16);
    assign is_ret    = is_rtd8 || is_rtd16 ||
                       ((instr.b0 == pbr_pkg::OP_PAGE_GRP) && (instr.b1 == pbr_pkg::SUB_RET));
    // Page group wins over a rotate whose address byte happens to be 11
    assign page_op   = is_jump || is_call || is_ret;
    assign is_rot_left = !page_op && (instr.b1 == pbr_pkg::OP_ROT_LEFT);
    assign dec_cp    = is_abs ? instr.b1 : gpr[rsel][7:0];
    assign dec_pc    = is_abs ? {instr.b2, instr.b3} : gpr[rsel_pair];
    assign ret_pc    = instr_pc + (is_abs ? pbr_pkg::LEN_ABS : pbr_pkg::LEN_IND);
    assign dec_imm   = is_rtd16 ? {instr.b2, instr.b3}
                     : is_rtd8  ? {{8{instr.b2[7]}}, instr.b2} : pbr_pkg::RST_WORD;
    assign rot_val   = rot_left(rot_operand, rot_word);

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        nxt_state     = state_ff;
        nxt_tgt_cp    = tgt_cp_ff;
        nxt_tgt_pc    = tgt_pc_ff;
        nxt_imm       = imm_ff;
        nxt_done      = 1'b0;
        nxt_inval     = 1'b0;
        nxt_aerr      = 1'b0;
        nxt_busy      = busy_ff;
        nxt_cp        = cp_ff;
        nxt_pc        = pc_ff;
        nxt_sp        = sp_ff;
        nxt_ccr       = ccr_ff;
        nxt_result    = result_ff;
        nxt_mem_req   = mem_req_ff;
        nxt_mem_we    = mem_we_ff;
        nxt_mem_addr  = mem_addr_ff;
        nxt_mem_wdata = mem_wdata_ff;
        unique case (state_ff)
            pbr_pkg::ST_IDLE:
            begin
                if (instr_valid)
                begin
                    nxt_sp  = sp_in;
                    nxt_cp  = cp_in;
                    nxt_ccr = ccr_in;
                    if (page_op && min_mode)
                    begin
                        nxt_inval = 1'b1;
                    end
                    else if (is_jump)
                    begin
                        nxt_cp   = dec_cp;
                        nxt_pc   = dec_pc;
                        nxt_done = 1'b1;
                    end
                    else if ((is_call || is_ret) && sp_in[0])
                    begin
                        nxt_aerr = 1'b1;
                    end
                    else if (is_call)
                    begin
                        nxt_tgt_cp    = dec_cp;
                        nxt_tgt_pc    = dec_pc;
                        nxt_mem_req   = 1'b1;
                        nxt_mem_we    = 1'b1;
                        nxt_mem_addr  = sp_in - pbr_pkg::WORD_STEP;
                        nxt_mem_wdata = ret_pc;
                        nxt_busy      = 1'b1;
                        nxt_state     = pbr_pkg::ST_PUSH_PC;
                    end
                    else if (is_ret)
                    begin
                        nxt_imm      = dec_imm;
                        nxt_mem_req  = 1'b1;
                        nxt_mem_we   = 1'b0;
                        nxt_mem_addr = sp_in;
                        nxt_busy     = 1'b1;
                        nxt_state    = pbr_pkg::ST_POP_CP;
                    end
                    else if (is_rot_left)
                    begin
                        nxt_result      = rot_val[15:0];
                        nxt_ccr[pbr_pkg::FLAG_C] = rot_val[16];
                        nxt_ccr[pbr_pkg::FLAG_N] = rot_val[rot_word ? 15 : 7];
                        nxt_ccr[pbr_pkg::FLAG_Z] = rot_word ? (rot_val[15:0] == 16'h0000)
                            : (rot_val[7:0] == 8'h00);
                        nxt_ccr[pbr_pkg::FLAG_V] = 1'b0;
                        nxt_done        = 1'b1;
                    end
                    else
                    begin
                        nxt_inval = 1'b1;
                    end
                end
            end
            pbr_pkg::ST_PUSH_PC:
            begin
                if (mem_ack)
                begin
                    nxt_sp        = sp_ff - pbr_pkg::WORD_STEP;
                    nxt_mem_addr  = sp_ff - pbr_pkg::PAIR_STEP;
                    nxt_mem_wdata = {pbr_pkg::RST_BYTE, cp_ff};
                    nxt_state     = pbr_pkg::ST_PUSH_CP;
                end
            end
            pbr_pkg::ST_PUSH_CP:
            begin
                if (mem_ack)
                begin
                    nxt_sp      = sp_ff - pbr_pkg::WORD_STEP;
                    nxt_cp      = tgt_cp_ff;
                    nxt_pc      = tgt_pc_ff;
                    nxt_mem_req = 1'b0;
                    nxt_mem_we  = 1'b0;
                    nxt_busy    = 1'b0;
                    nxt_done    = 1'b1;
                    nxt_state   = pbr_pkg::ST_IDLE;
                end
            end
            pbr_pkg::ST_POP_CP:
            begin
                if (mem_ack)
                begin
                    nxt_cp       = mem_rdata[7:0];
                    nxt_sp       = sp_ff + pbr_pkg::WORD_STEP;
                    nxt_mem_addr = sp_ff + pbr_pkg::WORD_STEP;
                    nxt_state    = pbr_pkg::ST_POP_PC;
                end
            end
            pbr_pkg::ST_POP_PC:
            begin
                if (mem_ack)
                begin
                    nxt_pc      = mem_rdata;
                    // Odd immediate leaves an odd pointer; next stack use faults
                    nxt_sp      = sp_ff + pbr_pkg::WORD_STEP + imm_ff;
                    nxt_mem_req = 1'b0;
                    nxt_busy    = 1'b0;
                    nxt_done    = 1'b1;
                    nxt_state   = pbr_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff     <= pbr_pkg::ST_IDLE;
            tgt_cp_ff    <= pbr_pkg::RST_BYTE;
            tgt_pc_ff    <= pbr_pkg::RST_WORD;
            imm_ff       <= pbr_pkg::RST_WORD;
            done_ff      <= 1'b0;
            inval_ff     <= 1'b0;
            aerr_ff      <= 1'b0;
            busy_ff      <= 1'b0;
            cp_ff        <= pbr_pkg::RST_BYTE;
            pc_ff        <= pbr_pkg::RST_WORD;
            sp_ff        <= pbr_pkg::RST_WORD;
            ccr_ff       <= pbr_pkg::RST_FLAGS;
            result_ff    <= pbr_pkg::RST_WORD;
            mem_req_ff   <= 1'b0;
            mem_we_ff    <= 1'b0;
            mem_addr_ff  <= pbr_pkg::RST_WORD;
            mem_wdata_ff <= pbr_pkg::RST_WORD;
        end
        else
        begin
            state_ff     <= nxt_state;
            tgt_cp_ff    <= nxt_tgt_cp;
            tgt_pc_ff    <= nxt_tgt_pc;
            imm_ff       <= nxt_imm;
            done_ff      <= nxt_done;
            inval_ff     <= nxt_inval;
            aerr_ff      <= nxt_aerr;
            busy_ff      <= nxt_busy;
            cp_ff        <= nxt_cp;
            pc_ff        <= nxt_pc;
            sp_ff        <= nxt_sp;
            ccr_ff       <= nxt_ccr;
            result_ff    <= nxt_result;
            mem_req_ff   <= nxt_mem_req;
            mem_we_ff    <= nxt_mem_we;
            mem_addr_ff  <= nxt_mem_addr;
            mem_wdata_ff <= nxt_mem_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_call_start;
        accept && is_call && !min_mode && !sp_in[0];
    endsequence
    sequence s_pc_pushed;
        (state_ff == pbr_pkg::ST_PUSH_PC) && mem_ack;
    endsequence

    a_jump_target: assert property (accept && is_jump && !min_mode |=>
        done_ff && cp_ff == $past(dec_cp) && pc_ff == $past(dec_pc))
        else $error("page jump target not loaded");
    a_jump_reg_pair: assert property (accept && is_jump && !is_abs && !min_mode |=>
        pc_ff == $past(gpr[rsel_pair]) && cp_ff == $past(gpr[rsel][7:0]))
        else $error("indirect pair not used");
    a_min_mode_inval: assert property (accept && page_op && min_mode |=>
        inval_ff && !done_ff && !mem_req_ff)
        else $error("page op not refused in minimum mode");
    a_call_push_pc: assert property (s_call_start |=>
        mem_req_ff && mem_we_ff && mem_wdata_ff == $past(ret_pc) &&
        mem_addr_ff == $past(sp_in) - pbr_pkg::WORD_STEP)
        else $error("return counter not pushed first");
    a_call_push_cp: assert property (s_pc_pushed |=>
        mem_we_ff && mem_wdata_ff[7:0] == $past(cp_ff) &&
        mem_addr_ff == $past(sp_ff) - pbr_pkg::PAIR_STEP)
        else $error("code page not pushed second");
    a_ret_pop_order: assert property ((state_ff == pbr_pkg::ST_POP_CP) && mem_ack |=>
        state_ff == pbr_pkg::ST_POP_PC && cp_ff == $past(mem_rdata[7:0]) &&
        mem_addr_ff == $past(sp_ff) + pbr_pkg::WORD_STEP)
        else $error("page not popped before counter");
    a_ret_sp_adjust: assert property ((state_ff == pbr_pkg::ST_POP_PC) && mem_ack |=>
        done_ff && sp_ff == $past(sp_ff) + pbr_pkg::WORD_STEP + $past(imm_ff))
        else $error("stack pointer not deallocated");
    a_imm_sign_ext: assert property (accept && is_rtd8 && !min_mode && !sp_in[0] |=>
        imm_ff[15:8] == {8{imm_ff[7]}})
        else $error("short immediate not sign extended");
    a_odd_sp_error: assert property (accept && (is_call || is_ret) &&
        !min_mode && sp_in[0] |=> aerr_ff && !mem_req_ff && !busy_ff)
        else $error("odd stack pointer not faulted");
    a_page_flags_kept: assert property (accept && page_op |=>
        ccr_ff == $past(ccr_in) ##1 (ccr_ff == $past(ccr_ff) || $past(accept))[*3])
        else $error("page op changed flags");
    a_rot_left_flags: assert property (accept && is_rot_left |=> done_ff &&
        ccr_ff[pbr_pkg::FLAG_V] == 1'b0 &&
        ccr_ff[pbr_pkg::FLAG_C] == $past(rot_word ? rot_operand[15] : rot_operand[7]) &&
        result_ff[0] == ccr_ff[pbr_pkg::FLAG_C])
        else $error("rotate carry or overflow wrong");
    a_rot_left_nz: assert property (accept && is_rot_left |=>
        ccr_ff[pbr_pkg::FLAG_N] == ($past(rot_word) ? result_ff[15] : result_ff[7]) &&
        ccr_ff[pbr_pkg::FLAG_Z] == ($past(rot_word) ? (result_ff == 16'h0000)
                                                    : (result_ff[7:0] == 8'h00)))
        else $error("rotate N or Z wrong");
endmodule : pbr_exec

// *** pbr_exec_tb.sv ***
// Purpose: Self-checking bench for pbr_exec
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Stack words are inspected inside the memory model
`timescale 1ns/1ps
module pbr_exec_tb;
    logic                ref_clk, rst_n, instr_valid, min_mode, rot_word, mem_ack;
    pbr_pkg::pbr_instr_s instr;
    logic [15:0]         instr_pc, sp_in, rot_operand, mem_rdata;
    logic [7:0]          cp_in;
    logic [3:0]          ccr_in, ack_dly;
    logic [7:0][15:0]    gpr;
    logic                done_ff, inval_ff, aerr_ff, busy_ff, mem_req_ff, mem_we_ff;
    logic [7:0]          cp_ff;
    logic [15:0]         pc_ff, sp_ff, result_ff, mem_addr_ff, mem_wdata_ff;
    logic [3:0]          ccr_ff;
    int                  errors, cmp_count, cycles;

    pbr_exec dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr(instr), .instr_pc(instr_pc), .cp_in(cp_in), .sp_in(sp_in),
        .ccr_in(ccr_in), .min_mode(min_mode), .gpr(gpr), .rot_operand(rot_operand),
        .rot_word(rot_word), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .done_ff(done_ff), .inval_ff(inval_ff), .aerr_ff(aerr_ff), .busy_ff(busy_ff),
        .cp_ff(cp_ff), .pc_ff(pc_ff), .sp_ff(sp_ff), .ccr_ff(ccr_ff),
        .result_ff(result_ff), .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff),
        .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff));

    pbr_mem_model mdl (.ref_clk(ref_clk), .ack_dly(ack_dly), .mem_req(mem_req_ff),
        .mem_we(mem_we_ff), .mem_addr(mem_addr_ff), .mem_wdata(mem_wdata_ff),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bounded wait so a silent design cannot hang the task
    task automatic issue(input logic [31:0] word, input logic [15:0] sp);
        int n;
        // One idle edge first so valid never drops and rises in one step
        @(posedge ref_clk);
        #1;
        instr       = word;
        sp_in       = sp;
        instr_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        instr_valid = 1'b0;
        n = 0;
        while (n < 40 && done_ff !== 1'b1 && inval_ff !== 1'b1 && aerr_ff !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask : issue

    task automatic res(input logic [7:0] cp, input logic [15:0] pc, input logic [15:0] sp);
        chk("done_ff", 16'h0001, {15'h0000, done_ff});
        chk("busy_ff", 16'h0000, {15'h0000, busy_ff});
        chk("cp_ff", {8'h00, cp}, {8'h00, cp_ff});
        chk("pc_ff", pc, pc_ff);
        chk("sp_ff", sp, sp_ff);
        chk("ccr_ff", {12'h000, ccr_in}, {12'h000, ccr_ff});
    endtask : res

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_jump;
        issue(32'h135A1234, 16'h0100);
        res(8'h5A, 16'h1234, 16'h0100);
        for (int r = 0; r < 8; r += 2)
        begin
            issue({8'h11, 8'hC0 | 8'(r), 16'h0000}, 16'h0100);
            res(gpr[r][7:0], gpr[r + 1], 16'h0100);
        end
        $display("test jump done");
    endtask : t_jump

    task automatic t_min;
        logic [31:0] ops [7] = '{32'h135A1234, 32'h035A1234, 32'h11C20000,
                                 32'h11CA0000, 32'h11140400, 32'h111C0004, 32'h11190000};
        min_mode = 1'b1;
        foreach (ops[k])
        begin
            issue(ops[k], 16'h0100);
            chk("inval_ff", 16'h0001, {15'h0000, inval_ff});
            chk("mem_req_ff", 16'h0000, {15'h0000, mem_req_ff});
        end
        min_mode = 1'b0;
        $display("test min_mode done");
    endtask : t_min

    task automatic t_call;
        ack_dly  = 4'h3;
        issue(32'h0307BEEF, 16'h0200);
        res(8'h07, 16'hBEEF, 16'h01FC);
        chk("ret_pc", 16'h1004, mdl.mem[16'h01FE]);
        chk("ret_cp", 16'h0033, mdl.mem[16'h01FC]);
        ack_dly = 4'h0;
        cp_in   = 8'h44;
        issue(32'h11190000, 16'h01FC);
        res(8'h33, 16'h1004, 16'h0200);
        ack_dly  = 4'h2;
        instr_pc = 16'h2000;
        issue(32'h11CC0000, 16'h0400);
        res(gpr[4][7:0], gpr[5], 16'h03FC);
        chk("ret_pc", 16'h2002, mdl.mem[16'h03FE]);
        chk("ret_cp", 16'h0044, mdl.mem[16'h03FC]);
        $display("test call done");
    endtask : t_call

    task automatic t_rtd;
        mdl.mem[16'h0300] = 16'hAB77;
        mdl.mem[16'h0302] = 16'h2468;
        issue(32'h11148000, 16'h0300);
        res(8'h77, 16'h2468, 16'h0284);
        issue(32'h11147E00, 16'h0300);
        res(8'h77, 16'h2468, 16'h0382);
        issue(32'h111C8000, 16'h0300);
        res(8'h77, 16'h2468, 16'h8304);
        issue(32'h0307BEEF, 16'h0201);
        chk("aerr_ff", 16'h0001, {15'h0000, aerr_ff});
        chk("mem_req_ff", 16'h0000, {15'h0000, mem_req_ff});
        issue(32'h11190000, 16'h0203);
        chk("aerr_ff", 16'h0001, {15'h0000, aerr_ff});
        $display("test return done");
    endtask : t_rtd

    task automatic t_rot;
        // Size, operand, result, flags N Z V C
        logic [36:0] tab [5] = '{{1'b0, 16'hFF81, 16'h0003, 4'h1},
                                 {1'b0, 16'hFF00, 16'h0000, 4'h4},
                                 {1'b0, 16'h0040, 16'h0080, 4'h8},
                                 {1'b1, 16'h8001, 16'h0003, 4'h1},
                                 {1'b1, 16'hFFFF, 16'hFFFF, 4'h9}};
        ccr_in = 4'hE;
        foreach (tab[k])
        begin
            rot_word    = tab[k][36];
            rot_operand = tab[k][35:20];
            issue(32'hA01C0000, 16'h0100);
            chk("result_ff", tab[k][19:4], result_ff);
            chk("ccr_ff", 16'(tab[k][3:0]), 16'(ccr_ff));
        end
        issue(32'hA0FF0000, 16'h0100);
        chk("inval_ff", 16'h0001, {15'h0000, inval_ff});
        ccr_in = 4'hA;
        $display("test rotate done");
    endtask : t_rot

    // ------------------------------------------------------------------------
    // Clock, limit and sequence
    // ------------------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            $display("BAD cycle_limit expected %0d seen %0d", 2999, cycles);
            finish_test;
        end
    end

    initial
    begin
        {rst_n, instr_valid, min_mode, rot_word} = 4'h0;
        instr       = '0;
        instr_pc    = 16'h1000;
        cp_in       = 8'h33;
        sp_in       = 16'h0100;
        ccr_in      = 4'hA;
        rot_operand = 16'h0000;
        ack_dly     = 4'h0;
        errors      = 0;
        cmp_count   = 0;
        cycles      = 0;
        for (int i = 0; i < 8; i++)
            gpr[i] = {4'hA, 4'(i), 4'h5, 4'(i)};
        repeat (16) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_jump();
        t_min();
        t_call();
        t_rtd();
        t_rot();
        finish_test();
    end
endmodule : pbr_exec_tb

// *** pbr_mem_model.sv ***
// Purpose: Stack memory partner for pbr_exec
// Assumes: 16-bit words addressed by stack offset
// Notes:   ack_dly sets wait cycles; idle read data toggles
`timescale 1ns/1ps
module pbr_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [3:0]  ack_dly,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic             mem_ack,
    output logic [15:0]      mem_rdata
);
    logic [15:0] mem [0:65535];
    logic [3:0]  wait_cnt;

    initial
    begin
        mem_ack   = 1'b0;
        mem_rdata = 16'h0000;
        wait_cnt  = 4'h0;
    end

    // Data toggles off the ack cycle so a stale word cannot pass as valid
    always @(posedge ref_clk)
    begin
        if (mem_ack)
        begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end
        else if (mem_req && wait_cnt == ack_dly)
        begin
            mem_ack <= 1'b1;
            if (mem_we)
                mem[mem_addr] <= mem_wdata;
            else
                mem_rdata <= mem[mem_addr];
        end
        else
        begin
            wait_cnt  <= mem_req ? wait_cnt + 4'h1 : 4'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : pbr_mem_model

// *** pbr_pkg.sv ***
// Purpose: Constants and types for the page branch and rotate executor
// Assumes: Instruction bytes arrive already fetched; stack words are 16 bits
// Notes:   Stack addresses are offsets inside the stack page
// ----------------------------------------------------------------------------
// Summary of operation
// - Page jump loads code page and program counter from the target.
// - Indirect form takes page from low byte of reg n, counter from n+1.
// - All page jump, call and return forms are invalid in minimum mode.
// - Page call pushes counter, then code page, with pre-decrement.
// - The pushed return location is the instruction after the call.
// - Absolute page call is opcode 03 then page, high, low bytes.
// - Indirect page call is 11 then C8 plus register number.
// - Return-deallocate pops page, then counter, then adds immediate.
// - Immediate is signed 8-bit or signed 16-bit.
// - Stack access with odd stack pointer raises an address error.
// - Plain page return pops page then counter and resumes there.
// - Page jump, call and return leave N, Z, V, C unchanged.
// - Rotate left feeds old top bit to bit zero and to carry.
// - Rotate left sets N from the result's top bit.
// - Rotate left sets Z when the sized result is zero.
// - Rotate left always clears V.
// ----------------------------------------------------------------------------
package pbr_pkg;
    // ------------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------------
    localparam logic [7:0]  OP_CALL_ABS  = 8'h03;
    localparam logic [7:0]  OP_JUMP_ABS  = 8'h13;
    localparam logic [7:0]  OP_PAGE_GRP  = 8'h11;
    localparam logic [7:0]  SUB_IND_MASK = 8'hF8;
    localparam logic [7:0]  SUB_JUMP_IND = 8'hC0;
    localparam logic [7:0]  SUB_CALL_IND = 8'hC8;
    localparam logic [7:0]  SUB_RTD8     = 8'h14;
    localparam logic [7:0]  SUB_RTD16    = 8'h1C;
    localparam logic [7:0]  SUB_RET      = 8'h19;
    localparam logic [7:0]  OP_ROT_LEFT  = 8'h1C;
    // ------------------------------------------------------------------------
    // Lengths, steps, flag positions
    // ------------------------------------------------------------------------
    localparam logic [15:0] LEN_ABS      = 16'h0004;
    localparam logic [15:0] LEN_IND      = 16'h0002;
    localparam logic [15:0] WORD_STEP    = 16'h0002;
    localparam logic [15:0] PAIR_STEP    = 16'h0004;
    localparam int          FLAG_N       = 3;
    localparam int          FLAG_Z       = 2;
    localparam int          FLAG_V       = 1;
    localparam int          FLAG_C       = 0;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [3:0]  RST_FLAGS    = 4'h0;

    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } pbr_instr_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH_PC,
        ST_PUSH_CP,
        ST_POP_CP,
        ST_POP_PC
    } pbr_state_e;
endpackage : pbr_pkg
